// >>> utf_fault_resp.sv
`timescale 1ns/1ps
`include "utf_cfg.svh"

module utf_fault_resp
	import utf_pkg::*;
(
	// clock and reset
	input  wire logic        ref_clk,
	input  wire logic        rst,
	input  wire logic        ce,
	// command port
	input  wire utf_cmd_t    cmd,
	input  wire logic [7:0]  rd_code,
	output logic      [15:0] rd_data,
	// converter side
	input  wire logic [15:0] temperature,
	input  wire logic        on_req,
	input  wire logic        other_fault,
	output logic             output_en,
	output logic             ut_fault
);

	////////////////////////////////////////////////////////////////////////
	// registers

	logic [15:0]            ut_limit_ff;
	utf_resp_t              resp_ff;
	logic [15:0]            unit_ff;
	logic                   flag_ff;
	utf_state_t             state_ff;
	utf_state_t             nxt_state;
	logic [`UTF_TIMER_W-1:0] tmr_ff;
	logic [`UTF_TIMER_W-1:0] nxt_tmr;
	logic [2:0]             tries_ff;
	logic [2:0]             nxt_tries;
	logic                   out_ff;
	logic [15:0]            rd_ff;
	logic                   ld_tmr;

	////////////////////////////////////////////////////////////////////////
	// helpers

	// delay length in cycles; a zero unit is taken as one to avoid a stall
	function automatic logic [`UTF_TIMER_W-1:0] delay_cycles(
		input logic [15:0] unit,
		input logic [2:0]  n
	);
		logic [`UTF_TIMER_W-1:0] u;
		u = {7'h00, unit};
		if (unit == 16'h0000) begin
			u = {{(`UTF_TIMER_W-1){1'b0}}, 1'b1};
		end
		return u << n;
	endfunction

	// one write-strobe decode shared by every register and clear
	function automatic logic cmd_hit(
		input utf_cmd_t   c,
		input logic [7:0] code
	);
		return c.wr && (c.code == code);
	endfunction

	// states in which the converter output may run
	function automatic logic runs_output(input utf_state_t s);
		return (s == UTF_RUN) || (s == UTF_DELAY) || (s == UTF_TRY);
	endfunction

	// status word with the under-temperature bit in its place
	function automatic logic [15:0] status_word(input logic flag);
		logic [15:0] w;
		w = 16'h0000;
		w[`UTF_STATUS_UT_BIT] = flag;
		return w;
	endfunction

	// unmapped codes read as zero so a host scan of the space is harmless
	function automatic logic [15:0] read_select(
		input logic [7:0]  code,
		input logic [15:0] limit,
		input utf_resp_t   resp,
		input logic [15:0] unit,
		input logic        flag
	);
		logic [15:0] w;
		w = 16'h0000;
		case (code)
			`UTF_CMD_UT_LIMIT:    w = limit;
			`UTF_CMD_UT_ACTION:   w = {8'h00, resp};
			`UTF_CMD_DELAY_UNIT:  w = unit;
			`UTF_CMD_STATUS_TEMP: w = status_word(flag);
			default:              w = 16'h0000;
		endcase
		return w;
	endfunction

	////////////////////////////////////////////////////////////////////////
	// decode

	wire wr_limit  = cmd_hit(cmd, `UTF_CMD_UT_LIMIT);
	wire wr_action = cmd_hit(cmd, `UTF_CMD_UT_ACTION);
	wire wr_unit   = cmd_hit(cmd, `UTF_CMD_DELAY_UNIT);
	wire clr_all   = cmd_hit(cmd, `UTF_CMD_CLEAR_FAULTS);
	wire clr_bit   = cmd_hit(cmd, `UTF_CMD_STATUS_TEMP)
		&& cmd.data[`UTF_STATUS_UT_BIT];
	wire clr_fault = clr_all || clr_bit;

	// raw signed compare; the linear format shares a common exponent here
	wire fault_now = $signed(temperature) < $signed(ut_limit_ff);
	wire tmr_done  = (tmr_ff == '0);
	wire forever_r = (resp_ff.retries == `UTF_RETRY_FOREVER);
	wire no_retry  = (resp_ff.retries == `UTF_RETRY_NONE);
	wire tries_out = !forever_r && (tries_ff >= resp_ff.retries);

	wire [`UTF_TIMER_W-1:0] dly = delay_cycles(unit_ff, resp_ff.delay);

	wire [15:0] rd_mux = read_select(rd_code, ut_limit_ff, resp_ff, unit_ff, flag_ff);

	////////////////////////////////////////////////////////////////////////
	// response sequencer

	always_comb begin
		nxt_state = state_ff;
		nxt_tries = tries_ff;
		ld_tmr    = 1'b0;
		if (!on_req) begin
			// commanded off: ends retries and any latch
			nxt_state = UTF_RUN;
			nxt_tries = 3'h0;
		end else if (clr_fault && state_ff != UTF_RUN) begin
			nxt_state = UTF_RUN;
			nxt_tries = 3'h0;
		end else begin
			unique case (state_ff)
				UTF_RUN: begin
					if (fault_now) begin
						unique case (resp_ff.action)
							UTF_ACT_IGNORE: nxt_state = UTF_RUN;
							UTF_ACT_DELAYED: begin
								nxt_state = UTF_DELAY;
								ld_tmr    = 1'b1;
							end
							UTF_ACT_RETRY: begin
								nxt_state = no_retry ? UTF_LATCH : UTF_WAIT;
								ld_tmr    = 1'b1;
								nxt_tries = 3'h0;
							end
							UTF_ACT_LATCHOFF: nxt_state = UTF_LATCH;
						endcase
					end
				end
				UTF_DELAY: begin
					if (tmr_done) begin
						// fault still there at the end: shut down and retry, or latch off when no retries are set
						if (!fault_now) begin
							nxt_state = UTF_RUN;
						end else begin
							nxt_state = no_retry ? UTF_LATCH : UTF_WAIT;
							ld_tmr    = 1'b1;
							nxt_tries = 3'h0;
						end
					end
				end
				UTF_WAIT: begin
					if (other_fault) begin
						nxt_state = UTF_LATCH;
					end else if (tmr_done) begin
						nxt_state = UTF_TRY;
						ld_tmr    = 1'b1;
						if (!forever_r) begin
							nxt_tries = tries_ff + 3'h1;
						end
					end
				end
				UTF_TRY: begin
					if (other_fault) begin
						nxt_state = UTF_LATCH;
					end else if (fault_now) begin
						// timer keeps running so attempt starts stay evenly spaced
						nxt_state = tries_out ? UTF_LATCH : UTF_WAIT;
					end else if (tmr_done) begin
						nxt_state = UTF_RUN;
						nxt_tries = 3'h0;
					end
				end
				UTF_LATCH: nxt_state = UTF_LATCH;
				default: begin
					nxt_state = UTF_LATCH;
					nxt_tries = 3'h0;
				end
			endcase
		end
	end

	assign nxt_tmr = ld_tmr ? dly - 1'b1 : (tmr_done ? tmr_ff : tmr_ff - 1'b1);

	wire nxt_out = on_req && runs_output(nxt_state);

	////////////////////////////////////////////////////////////////////////
	// configuration registers

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			ut_limit_ff <= `UTF_RST_UT_LIMIT;
		end else if (ce && wr_limit) begin
			ut_limit_ff <= cmd.data;
		end
	end

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			resp_ff <= utf_resp_t'(`UTF_RST_UT_ACTION);
		end else if (ce && wr_action) begin
			resp_ff <= utf_resp_t'(cmd.data[7:0]);
		end
	end

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			unit_ff <= `UTF_RST_DELAY_UNIT;
		end else if (ce && wr_unit) begin
			unit_ff <= cmd.data;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// sequencer state

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			state_ff <= UTF_RUN;
		end else if (ce) begin
			state_ff <= nxt_state;
		end
	end

	// the timer parks at zero rather than wrapping, so a late look still sees done
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			tmr_ff <= '0;
		end else if (ce) begin
			tmr_ff <= nxt_tmr;
		end
	end

	// three bits cover the largest finite retry count
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			tries_ff <= 3'h0;
		end else if (ce) begin
			tries_ff <= nxt_tries;
		end
	end

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			out_ff <= 1'b0;
		end else if (ce) begin
			out_ff <= nxt_out;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// status flag and read port

	// a new fault wins over a clear in the same cycle
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			flag_ff <= 1'b0;
		end else if (ce) begin
			flag_ff <= fault_now || (flag_ff && !clr_fault);
		end
	end

	// registered read data costs a cycle but keeps decode glitches off the bus
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			rd_ff <= 16'h0000;
		end else if (ce) begin
			rd_ff <= rd_mux;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// outputs

	assign rd_data   = rd_ff;
	assign output_en = out_ff;
	assign ut_fault  = flag_ff;

endmodule // utf_fault_resp

// >>> utf_cfg.svh
`ifndef UTF_CFG_SVH
`define UTF_CFG_SVH

// command codes
`define UTF_CMD_CLEAR_FAULTS 8'h03
`define UTF_CMD_UT_LIMIT     8'h53
`define UTF_CMD_UT_ACTION    8'h54
`define UTF_CMD_STATUS_TEMP  8'h7D
`define UTF_CMD_DELAY_UNIT   8'hD2

// field positions and retry codes
`define UTF_STATUS_UT_BIT    4
`define UTF_RETRY_FOREVER    3'h7
`define UTF_RETRY_NONE       3'h0

// reset values
`define UTF_RST_UT_LIMIT     16'h8000
`define UTF_RST_UT_ACTION    8'hC0
`define UTF_RST_DELAY_UNIT   16'h0001

// timing
`define UTF_TIMER_W          23

`endif

// >>> utf_pkg.sv
package utf_pkg;

	typedef enum logic [2:0] {
		UTF_RUN   = 3'h0,
		UTF_DELAY = 3'h1,
		UTF_WAIT  = 3'h3,
		UTF_TRY   = 3'h2,
		UTF_LATCH = 3'h6
	} utf_state_t;

	typedef enum logic [1:0] {
		UTF_ACT_IGNORE   = 2'h0,
		UTF_ACT_DELAYED  = 2'h1,
		UTF_ACT_RETRY    = 2'h2,
		UTF_ACT_LATCHOFF = 2'h3
	} utf_action_t;

	typedef struct packed {
		utf_action_t action;
		logic [2:0]  retries;
		logic [2:0]  delay;
	} utf_resp_t;

	typedef struct packed {
		logic        wr;
		logic [7:0]  code;
		logic [15:0] data;
	} utf_cmd_t;

endpackage

// >>> utf_host.sv
`timescale 1ns/1ps
module utf_host
	import utf_pkg::*;
(
	// host side of the command port
	input  wire logic ref_clk,
	output utf_cmd_t  cmd
);
	initial cmd = '0;
	// strobe drops a cycle later so two writes never merge
	task automatic wr(input logic [7:0] code, input logic [15:0] data);
		@(posedge ref_clk);
		cmd <= '{1'b1, code, data};
		@(posedge ref_clk);
		cmd.wr <= 1'b0;
	endtask
endmodule // utf_host

// >>> utf_fault_resp_checker.sv
`timescale 1ns/1ps
module utf_fault_resp_checker
	import utf_pkg::*;
(
	// clock and reset
	input wire logic        ref_clk,
	input wire logic        rst,
	input wire logic        ce,
	// command and read port
	input wire utf_cmd_t    cmd,
	input wire logic [7:0]  rd_code,
	input wire logic [15:0] rd_data,
	// converter side
	input wire logic [15:0] temperature,
	input wire logic        on_req,
	input wire logic        other_fault,
	input wire logic        output_en,
	input wire logic        ut_fault
);
	//////////////////////////////
	// shadow copies, so limits are judged against what was written
	logic [15:0] thr_ff;
	logic [15:0] unit_ff;
	logic [7:0]  act_ff;
	wire         wr    = ce && cmd.wr;
	wire         flt   = $signed(temperature) < $signed(thr_ff);
	wire         onset = ce && flt && !ut_fault && output_en && on_req && !other_fault;
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			thr_ff  <= 16'h8000;
			act_ff  <= 8'hC0;
			unit_ff <= 16'h0001;
		end else begin
			if (wr && cmd.code == 8'h53)
				thr_ff <= cmd.data;
			if (wr && cmd.code == 8'h54)
				act_ff <= cmd.data[7:0];
			if (wr && cmd.code == 8'hD2)
				unit_ff <= cmd.data;
		end
	end
	//////////////////////////////
	default clocking @(posedge ref_clk); endclocking
	default disable iff rst;
	// only the unit 3, delay 1 case is timed: a general gap needs a counter
	sequence s_gap;
		!output_en [*6] ##1 output_en;
	endsequence
	a_flag_set: assert property (ce && flt |=> ut_fault)
		else $error("flag not set");
	a_flag_clear: assert property (wr && cmd.code == 8'h03 && !flt |=> !ut_fault)
		else $error("flag not cleared");
	a_ignore_runs: assert property (output_en && ce && on_req && !other_fault && act_ff[7:6] == 2'h0 |=> output_en)
		else $error("output dropped");
	a_disable_now: assert property (onset && act_ff[7] |=> !output_en)
		else $error("output not disabled");
	a_delay_run: assert property (onset && act_ff[7:6] == 2'h1 |=> output_en [*2])
		else $error("run-on cut short");
	a_retry_gap: assert property (onset && act_ff == 8'h89 && unit_ff == 16'h0003 |=> s_gap)
		else $error("attempt spacing wrong");
	a_latch_holds: assert property (act_ff[7:6] == 2'h3 && ut_fault && !output_en && on_req
		&& $past(on_req) && $past(on_req, 2) && !wr && !$past(wr) |=> !output_en)
		else $error("latched output came back");
	a_read_back: assert property (ce && !cmd.wr && rd_code == 8'h53 |=> rd_data == thr_ff)
		else $error("threshold read wrong");
endmodule // utf_fault_resp_checker

bind utf_fault_resp utf_fault_resp_checker chk_u (.ref_clk, .rst, .ce, .cmd, .rd_code,
	.rd_data, .temperature, .on_req, .other_fault, .output_en, .ut_fault);

// >>> utf_fault_resp_tb.sv
`timescale 1ns/1ps
module utf_fault_resp_tb
	import utf_pkg::*;
;
	logic        ref_clk     = 1'b0;
	logic        rst         = 1'b1;
	logic        on_req      = 1'b1;
	logic        other_fault = 1'b0;
	logic        ce          = 1'b1;
	logic [7:0]  rd_code     = 8'h00;
	logic [15:0] temperature = 16'h0000;
	logic [15:0] rd_data;
	logic [15:0] n;
	logic        output_en;
	logic        ut_fault;
	utf_cmd_t    cmd;
	int          mismatches      = 0;
	int          samples_checked = 0;
	int          cycles          = 0;
	// code, write data, value read back
	logic [39:0] rows [4] = '{{8'h53, 16'hFF00, 16'hFF00}, {8'h54, 16'h12AB, 16'h00AB},
		{8'h60, 16'h1234, 16'h0000}, {8'hD2, 16'h0003, 16'h0003}};
	logic [15:0] latch [2] = '{16'h00C0, 16'h0080};
	always #20 ref_clk = ~ref_clk;
	utf_host host_u (.ref_clk, .cmd);
	utf_fault_resp dut_u (.ref_clk, .rst, .ce, .cmd, .rd_code, .rd_data, .temperature,
		.on_req, .other_fault, .output_en, .ut_fault);
	//////////////////////////////
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		samples_checked++;
		if (got !== exp) begin
			mismatches++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic step(input int k);
		repeat (k) @(posedge ref_clk);
		#1;
	endtask
	task automatic rd(input logic [7:0] code, input logic [15:0] exp);
		@(posedge ref_clk);
		rd_code <= code;
		step(2);
		chk(rd_data, exp);
	endtask
	task automatic final_report();
		$display("compared %0d, wrong %0d", samples_checked, mismatches);
		if (mismatches == 0 && samples_checked > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	// a hang is cut short well past the few hundred cycles the run needs
	always @(posedge ref_clk) begin
		cycles++;
		if (cycles == 3000) begin
			mismatches++;
			final_report();
		end
	end
	//////////////////////////////
	initial begin
		repeat (16) @(posedge ref_clk);
		rst <= 1'b0;
		rd(8'h53, 16'h8000);
		rd(8'h54, 16'h00C0);
		foreach (rows[i]) begin
			host_u.wr(rows[i][39:32], rows[i][31:16]);
			rd(rows[i][39:32], rows[i][15:0]);
		end
		$display("register test done");
		host_u.wr(8'h54, 16'h0000);
		@(posedge ref_clk) temperature <= 16'hFE00;
		step(3);
		chk(16'(ut_fault), 16'h0001);
		chk(16'(output_en), 16'h0001);
		rd(8'h7D, 16'h0010);
		host_u.wr(8'h03, 16'h0000);
		step(1);
		chk(16'(ut_fault), 16'h0001);
		@(posedge ref_clk) temperature <= 16'h0000;
		host_u.wr(8'h7D, 16'h0010);
		step(1);
		chk(16'(ut_fault), 16'h0000);
		$display("ignore and clear test done");
		foreach (latch[i]) begin
			host_u.wr(8'h54, latch[i]);
			@(posedge ref_clk) temperature <= 16'hFE00;
			step(4);
			@(posedge ref_clk) temperature <= 16'h0000;
			step(20);
			chk(16'(output_en), 16'h0000);
			host_u.wr(8'h03, 16'h0000);
			step(3);
			chk(16'(output_en), 16'h0001);
		end
		$display("latch test done");
		host_u.wr(8'h54, 16'h0089);
		@(posedge ref_clk) temperature <= 16'hFE00;
		n = 16'h0000;
		do begin
			step(1);
			n++;
		end while (!(n > 2 && output_en === 1'b1) && n < 40);
		chk(n, 16'h0007);
		step(20);
		chk(16'(output_en), 16'h0000);
		@(posedge ref_clk) on_req <= 1'b0;
		temperature <= 16'h0000;
		@(posedge ref_clk) on_req <= 1'b1;
		step(3);
		chk(16'(output_en), 16'h0001);
		host_u.wr(8'h03, 16'h0000);
		$display("retry test done");
		host_u.wr(8'h54, 16'h0049);
		@(posedge ref_clk) temperature <= 16'hFE00;
		step(6);
		chk(16'(output_en), 16'h0001);
		step(4);
		chk(16'(output_en), 16'h0000);
		$display("run-on test done");
		// a write while the clock enable is low must be lost
		@(posedge ref_clk) ce <= 1'b0;
		host_u.wr(8'h53, 16'h1234);
		@(posedge ref_clk) ce <= 1'b1;
		rd(8'h53, 16'hFF00);
		@(posedge ref_clk) rst <= 1'b1;
		rd_code <= 8'h54;
		step(2);
		chk(16'(output_en), 16'h0000);
		chk(16'(ut_fault), 16'h0000);
		@(posedge ref_clk) rst <= 1'b0;
		temperature <= 16'h0000;
		rd(8'h54, 16'h00C0);
		chk(16'(output_en), 16'h0001);
		$display("freeze and reset test done");
		host_u.wr(8'h53, 16'hFF00);
		host_u.wr(8'h54, 16'h00B8);
		@(posedge ref_clk) temperature <= 16'hFE00;
		step(30);
		n = 16'h0000;
		repeat (4) begin
			step(1);
			n += 16'(output_en);
		end
		chk(n, 16'h0002);
		@(posedge ref_clk) other_fault <= 1'b1;
		step(3);
		chk(16'(output_en), 16'h0000);
		$display("endless retry test done");
		final_report();
	end
endmodule // utf_fault_resp_tb
